// file: hdl/smc_standby_ctrl.sv
// standby mode control: apb registers, standby state machine, clock gating
`timescale 1ns/10ps

// Notes on behaviour
// - masks never block halt release
// - masks written with trigger are discarded
// - mode bits act only with trigger set
// - settle count starts once oscillator runs
// - reset or interrupt release stop alike
// - reset select six gives 2^16 cycle wait
// - pending request ends halt right away
// - masked source cannot release idle
module smc_standby_ctrl
    import smc_pkg::*;
#(
    parameter int unsigned SETTLE_BASE_LOG2 = smc_pkg::SETTLE_BASE_LOG2_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [smc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_req,
    input wire logic nmi_a_req,
    input wire logic nmi_b_req,
    input wire logic int_req,
    input wire logic osc_running,
    output logic osc_enable,
    output logic cpu_clk_run,
    output logic periph_clk_run
);
    import smc_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    smc_state_t st_q;
    smc_state_t st_d;
    smc_mode_t mode_q;
    logic [WAKE_N-1:0] mask_q;
    logic [SEL_W-1:0] sel_q;
    logic trig_q;
    logic rd_valid_q;
    logic [31:0] prdata_q;
    logic osc_en_q;
    logic cpu_run_q;
    logic periph_run_q;
    logic [WAKE_N-1:0] req;
    logic wake;
    logic settle_done;
    logic settle_start;
    logic fire;
    logic wr_fire;
    logic mapped;
    logic [31:0] rd_mux;
    logic [31:0] status;

    // ----------------------------------------------------------------
    // apb slave: data loaded on the first enabled edge with psel,
    // answered on the following access edge
    // ----------------------------------------------------------------
    function automatic logic smc_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        smc_hit = (a == o);
    endfunction : smc_hit

    assign mapped = smc_hit(paddr, OFS_CTRL) | smc_hit(paddr, OFS_MODE)
        | smc_hit(paddr, OFS_SETTLE) | smc_hit(paddr, OFS_STATUS);
    assign pready = psel & penable & rd_valid_q & pclk_en;
    assign pslverr = pready & ~mapped;
    assign fire = pready;
    assign wr_fire = fire & pwrite & mapped;
    assign prdata = prdata_q;

    always_comb
    begin
        status = RD_ZERO;
        status[STAT_STATE_LSB +: 3] = st_q;
        status[STAT_MODE_LSB +: MODE_W] = mode_q;
        status[STAT_OSC_RUN] = osc_running;
        status[STAT_OSC_EN] = osc_en_q;
        status[STAT_TRIGGER] = trig_q;
    end

    always_comb
    begin
        rd_mux = RD_ZERO;
        if (smc_hit(paddr, OFS_CTRL))
        begin
            rd_mux[BIT_MASK_A] = mask_q[0];
            rd_mux[BIT_MASK_B] = mask_q[1];
            rd_mux[BIT_MASK_INT] = mask_q[2];
            rd_mux[BIT_TRIGGER] = trig_q;
        end
        else if (smc_hit(paddr, OFS_MODE))
            rd_mux[MODE_W-1:0] = mode_q;
        else if (smc_hit(paddr, OFS_SETTLE))
            rd_mux[SEL_W-1:0] = sel_q;
        else if (smc_hit(paddr, OFS_STATUS))
            rd_mux = status;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_valid_q <= 1'b0;
            prdata_q <= RD_ZERO;
        end
        else if (pclk_en)
        begin
            if (fire)
                rd_valid_q <= 1'b0;
            else if (psel && !rd_valid_q)
            begin
                rd_valid_q <= 1'b1;
                prdata_q <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= MASK_RST;
        else if (pclk_en && wr_fire && smc_hit(paddr, OFS_CTRL) && !pwdata[BIT_TRIGGER])
            mask_q <= {pwdata[BIT_MASK_INT], pwdata[BIT_MASK_B], pwdata[BIT_MASK_A]};
    end

    // trigger stays set through standby and drops on release; a write wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_q <= 1'b0;
        else if (pclk_en)
        begin
            if (wr_fire && smc_hit(paddr, OFS_CTRL) && pwdata[BIT_TRIGGER])
                trig_q <= 1'b1;
            else if (st_q != ST_RUN && st_d == ST_RUN)
                trig_q <= 1'b0;
        end
    end

    // upper bits are not stored and read back as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= MODE_IDLE_LEVEL_ONE;
        else if (pclk_en && wr_fire && smc_hit(paddr, OFS_MODE))
            mode_q <= smc_mode_t'(pwdata[MODE_W-1:0]);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sel_q <= SETTLE_SEL_RST;
        else if (pclk_en && wr_fire && smc_hit(paddr, OFS_SETTLE))
            sel_q <= pwdata[SEL_W-1:0];
    end

    // ----------------------------------------------------------------
    // wake decode and settle wait
    // ----------------------------------------------------------------
    assign req = {int_req, nmi_b_req, nmi_a_req};
    assign settle_start = (st_q == ST_STOP) & wake;

    smc_wake_decode u_wake (
        .req(req),
        .mask(mask_q),
        .in_halt(st_q == ST_HALT),
        .wake(wake)
    );

    smc_settle_timer #(
        .BASE_LOG2(SETTLE_BASE_LOG2)
    ) u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .pclk_en(pclk_en),
        .start(settle_start),
        .osc_running(osc_running),
        .sel(sel_q),
        .done(settle_done)
    );

    // ----------------------------------------------------------------
    // standby state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_RUN:
                if (trig_q)
                    st_d = (mode_q == MODE_STOP) ? ST_STOP : ST_IDLE;
                else if (halt_req)
                    st_d = ST_HALT;
            ST_HALT:
                if (wake)
                    st_d = ST_RUN;
            ST_IDLE:
                if (wake)
                    st_d = ST_RUN;
            ST_STOP:
                if (wake)
                    st_d = ST_SETTLE;
            ST_SETTLE:
                if (settle_done)
                    st_d = ST_RUN;
            default:
                st_d = ST_SETTLE;
        endcase
    end

    // reset lands in the settle state, so the cpu waits out the oscillator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= ST_SETTLE;
        else if (pclk_en)
            st_q <= st_d;
    end

    // ----------------------------------------------------------------
    // clock gating outputs, registered from the next state
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_en_q <= 1'b1;
            cpu_run_q <= 1'b0;
            periph_run_q <= 1'b0;
        end
        else if (pclk_en)
        begin
            osc_en_q <= (st_d != ST_STOP);
            cpu_run_q <= (st_d == ST_RUN);
            // idle_level_two also stops peripherals; settle keeps cpu and peripheral clocks parked with the oscillator enabled
            periph_run_q <= (st_d == ST_RUN) || (st_d == ST_HALT)
                || (st_d == ST_IDLE && mode_q != MODE_IDLE_LEVEL_TWO);
        end
    end

    assign osc_enable = osc_en_q;
    assign cpu_clk_run = cpu_run_q;
    assign periph_clk_run = periph_run_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] chk_cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chk_cnt_q <= '0;
        else if (pclk_en)
        begin
            if (st_q != ST_SETTLE)
                chk_cnt_q <= '0;
            else if (osc_running)
                chk_cnt_q <= chk_cnt_q + CNT_W'(1);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_halt_ignores_mask: assert property (
        (st_q == ST_HALT && pclk_en && |req) |=> (st_q == ST_RUN))
        else $error("halt not released by a masked request");

    chk_mask_discard: assert property (
        (wr_fire && smc_hit(paddr, OFS_CTRL) && pwdata[BIT_TRIGGER]) |=> $stable(mask_q))
        else $error("mask written together with trigger was kept");

    chk_mode_needs_trigger: assert property (
        (st_q == ST_RUN && pclk_en && !trig_q && !halt_req) |=> (st_q == ST_RUN))
        else $error("standby entered without trigger");

    chk_settle_waits_osc: assert property (
        (st_q == ST_SETTLE && !osc_running) |=> (st_q == ST_SETTLE))
        else $error("settle ended while oscillator stopped");

    chk_stop_release: assert property (
        (st_q == ST_STOP && pclk_en && wake) |=> (st_q == ST_SETTLE) ##1 !cpu_clk_run)
        else $error("stop release skipped the settle wait");

    chk_settle_length: assert property (
        ($past(st_q) == ST_SETTLE && st_q == ST_RUN)
            |-> ($past(chk_cnt_q) == smc_settle_limit(sel_q, SETTLE_BASE_LOG2)))
        else $error("settle wait length wrong");

    chk_halt_pending: assert property (
        (st_q == ST_RUN && pclk_en && !trig_q && halt_req && |req)
            |=> (st_q == ST_HALT) ##1 (st_q == ST_RUN || !$past(pclk_en)))
        else $error("pending request did not end halt");

    chk_masked_idle: assert property (
        (st_q == ST_IDLE && pclk_en && ((req & ~mask_q) == '0)) |=> (st_q == ST_IDLE))
        else $error("masked source released idle");

    chk_stop_entry: assert property (
        (st_q == ST_RUN && pclk_en && trig_q && mode_q == MODE_STOP)
            |=> (st_q == ST_STOP) && !osc_enable && !cpu_clk_run)
        else $error("stop mode not entered from trigger");

    cov_halt_cycle: cover property (
        (st_q == ST_HALT) ##1 (st_q == ST_RUN));

    cov_idle_cycle: cover property (
        (st_q == ST_IDLE) ##1 (st_q == ST_RUN));

    cov_stop_settle: cover property (
        (st_q == ST_STOP) ##1 (st_q == ST_SETTLE));

    cov_bad_addr: cover property (pslverr);

endmodule : smc_standby_ctrl

// file: shared/smc_pkg.sv
// constants, types and shared decode for the standby mode control block
package smc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_MODE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_SETTLE = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int BIT_MASK_A = 0;
    localparam int BIT_MASK_B = 1;
    localparam int BIT_MASK_INT = 2;
    localparam int BIT_TRIGGER = 7;
    localparam int MODE_W = 2;
    localparam int SEL_W = 3;
    localparam int WAKE_N = 3;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_OSC_RUN = 8;
    localparam int STAT_OSC_EN = 9;
    localparam int STAT_TRIGGER = 10;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] SETTLE_SEL_RST = 3'h6;
    localparam logic [MODE_W-1:0] MODE_RST = 2'h0;
    localparam logic [WAKE_N-1:0] MASK_RST = 3'h0;
    localparam int CNT_W = 24;
    localparam int SETTLE_BASE_LOG2_DEF = 10;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [MODE_W-1:0] {
        MODE_IDLE_LEVEL_ONE = 2'h0,
        MODE_IDLE_LEVEL_TWO = 2'h1,
        MODE_STOP = 2'h2,
        MODE_SUBIDLE = 2'h3
    } smc_mode_t;

    // one bit changes along run -> stop -> settle; settle -> run changes two bits
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_HALT = 3'h1,
        ST_IDLE = 3'h3,
        ST_STOP = 3'h2,
        ST_SETTLE = 3'h6
    } smc_state_t;

    // last count value of the settle wait, in main oscillator cycles
    function automatic logic [CNT_W-1:0] smc_settle_limit(
        input logic [SEL_W-1:0] sel,
        input int unsigned base
    );
        logic [31:0] span;
        span = 32'h0000_0001 << (base + 32'(sel));
        smc_settle_limit = CNT_W'(span - 32'h0000_0001);
    endfunction : smc_settle_limit

endpackage : smc_pkg

// file: hdl/smc_wake_decode.sv
// wake decode: which pending requests may end the current standby state
`timescale 1ns/10ps
module smc_wake_decode
    import smc_pkg::*;
(
    input wire logic [smc_pkg::WAKE_N-1:0] req,
    input wire logic [smc_pkg::WAKE_N-1:0] mask,
    input wire logic in_halt,
    output logic wake
);
    import smc_pkg::*;

    logic [WAKE_N-1:0] src;

    // ----------------------------------------------------------------
    // per source gating
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WAKE_N; i++)
        begin : g_src
            // masks have no say over halt release
            assign src[i] = req[i] & (in_halt | ~mask[i]);
        end
    endgenerate

    assign wake = |src;

endmodule : smc_wake_decode

// file: hdl/smc_settle_timer.sv
// oscillation settle wait counter, counting only on a running oscillator
`timescale 1ns/10ps
module smc_settle_timer
    import smc_pkg::*;
#(
    parameter int unsigned BASE_LOG2 = smc_pkg::SETTLE_BASE_LOG2_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic start,
    input wire logic osc_running,
    input wire logic [smc_pkg::SEL_W-1:0] sel,
    output logic done
);
    import smc_pkg::*;

    logic active_q;
    logic [CNT_W-1:0] cnt_q;
    logic at_limit;

    assign at_limit = (cnt_q == smc_settle_limit(sel, BASE_LOG2));
    assign done = active_q & osc_running & at_limit;

    // ----------------------------------------------------------------
    // counter; armed out of reset so the first wait follows reset release
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_q <= 1'b1;
            cnt_q <= '0;
        end
        else if (pclk_en)
        begin
            if (start)
            begin
                active_q <= 1'b1;
                cnt_q <= '0;
            end
            else if (active_q && osc_running)
            begin
                if (at_limit)
                    active_q <= 1'b0;
                else
                    cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end

endmodule : smc_settle_timer

// file: bench/smc_standby_ctrl_tb.sv
// self-checking testbench for the standby mode control block
`timescale 1ns/10ps
module smc_standby_ctrl_tb;
    import smc_pkg::*;
    // ------------------------------------------------------------
    // stimulus and instance
    // ------------------------------------------------------------
    // short settle base keeps the reset wait at 256 cycles
    localparam int BL = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic halt_req = 1'b0;
    logic nmi_a_req = 1'b0;
    logic nmi_b_req = 1'b0;
    logic int_req = 1'b0;
    logic osc_running = 1'b0;
    logic pclk_en = 1'b1;
    logic osc_enable;
    logic cpu_clk_run;
    logic periph_clk_run;
    logic [31:0] rd;
    int miscompares = 0;
    int check_count = 0;

    smc_standby_ctrl #(.SETTLE_BASE_LOG2(BL)) smc_standby_ctrl_inst (
        .pclk(pclk),
        .presetn(presetn),
        .pclk_en(pclk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .halt_req(halt_req),
        .nmi_a_req(nmi_a_req),
        .nmi_b_req(nmi_b_req),
        .int_req(int_req),
        .osc_running(osc_running),
        .osc_enable(osc_enable),
        .cpu_clk_run(cpu_clk_run),
        .periph_clk_run(periph_clk_run)
    );

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    // settle a bit after the edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rd = pslverr ? 32'hFFFF_FFFF : prdata;
        // the slave answers with no wait state while the clock is enabled
        chk_bit("zero_wait", 1'b1, n == 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, OFS_SETTLE, '0);
        chk_word("settle_select", 32'h0000_0006, rd);
        cyc(300);
        chk_bit("cpu_clk_run", 1'b0, cpu_clk_run);
        chk_bit("osc_enable", 1'b1, osc_enable);
        @(posedge pclk);
        osc_running <= 1'b1;
        cyc((1 << (BL + 6)) - 1);
        chk_bit("cpu_clk_run", 1'b0, cpu_clk_run);
        cyc(1);
        chk_bit("cpu_clk_run", 1'b1, cpu_clk_run);
    endtask : t_reset

    task automatic t_regs();
        apb(1'b0, OFS_CTRL, '0);
        chk_word("control", 32'h0000_0000, rd);
        apb(1'b1, OFS_MODE, 32'h0000_0002);
        apb(1'b0, OFS_MODE, '0);
        chk_word("mode_select", 32'h0000_0002, rd);
        cyc(10);
        chk_bit("cpu_clk_run", 1'b1, cpu_clk_run);
        chk_bit("osc_enable", 1'b1, osc_enable);
        apb(1'b1, OFS_SETTLE, 32'h0000_0000);
        apb(1'b0, OFS_SETTLE, '0);
        chk_word("settle_select", 32'h0000_0000, rd);
        apb(1'b0, 12'h010, '0);
        chk_word("unmapped", 32'hFFFF_FFFF, rd);
    endtask : t_regs

    // settle select 0 gives a four-cycle wait here
    task automatic t_stop();
        apb(1'b1, OFS_CTRL, 32'h0000_0087);
        cyc(3);
        chk_bit("osc_enable", 1'b0, osc_enable);
        chk_bit("cpu_clk_run", 1'b0, cpu_clk_run);
        apb(1'b0, OFS_CTRL, '0);
        chk_word("control", 32'h0000_0080, rd);
        @(posedge pclk);
        osc_running <= 1'b0;
        int_req <= 1'b1;
        cyc(3);
        chk_bit("osc_enable", 1'b1, osc_enable);
        cyc(20);
        chk_bit("cpu_clk_run", 1'b0, cpu_clk_run);
        @(posedge pclk);
        osc_running <= 1'b1;
        int_req <= 1'b0;
        cyc(3);
        chk_bit("cpu_clk_run", 1'b0, cpu_clk_run);
        cyc(1);
        chk_bit("cpu_clk_run", 1'b1, cpu_clk_run);
        apb(1'b0, OFS_CTRL, '0);
        chk_word("control", 32'h0000_0000, rd);
    endtask : t_stop

    task automatic t_idle();
        logic [1:0] m;
        for (int i = 0; i < 3; i++)
        begin
            m = (i == 2) ? 2'h3 : 2'(i);
            apb(1'b1, OFS_MODE, {30'h0, m});
            apb(1'b1, OFS_CTRL, 32'h0000_0004);
            @(posedge pclk);
            int_req <= 1'b1;
            apb(1'b1, OFS_CTRL, 32'h0000_0081);
            apb(1'b0, OFS_CTRL, '0);
            chk_word("control", 32'h0000_0084, rd);
            cyc(5);
            chk_bit("cpu_clk_run", 1'b0, cpu_clk_run);
            chk_bit("periph_clk_run", m != 2'h1, periph_clk_run);
            @(posedge pclk);
            nmi_a_req <= 1'b1;
            cyc(3);
            chk_bit("cpu_clk_run", 1'b1, cpu_clk_run);
            @(posedge pclk);
            nmi_a_req <= 1'b0;
            int_req <= 1'b0;
        end
    endtask : t_idle

    task automatic t_halt();
        logic lo;
        lo = 1'b0;
        // a halt request while the clock enable is low must not be taken
        @(posedge pclk);
        pclk_en <= 1'b0;
        halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        @(posedge pclk);
        pclk_en <= 1'b1;
        cyc(2);
        chk_bit("frozen_halt", 1'b1, cpu_clk_run);
        apb(1'b1, OFS_CTRL, 32'h0000_0007);
        @(posedge pclk);
        halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        cyc(4);
        chk_bit("cpu_clk_run", 1'b0, cpu_clk_run);
        @(posedge pclk);
        nmi_b_req <= 1'b1;
        cyc(3);
        chk_bit("cpu_clk_run", 1'b1, cpu_clk_run);
        @(posedge pclk);
        halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        // the halt lasts one cycle, so look right after the entry edge
        repeat (6)
        begin
            #1;
            if (cpu_clk_run === 1'b0)
                lo = 1'b1;
            @(posedge pclk);
        end
        #1;
        chk_bit("halt_entered", 1'b1, lo);
        chk_bit("cpu_clk_run", 1'b1, cpu_clk_run);
        @(posedge pclk);
        nmi_b_req <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
    endtask : t_halt

    // stop left by reset: the full reset settle wait applies again
    task automatic t_stop_reset();
        apb(1'b1, OFS_MODE, 32'h0000_0002);
        apb(1'b1, OFS_CTRL, 32'h0000_0080);
        @(posedge pclk);
        osc_running <= 1'b0;
        cyc(3);
        chk_bit("osc_enable", 1'b0, osc_enable);
        do_reset();
        t_reset();
    endtask : t_stop_reset

    // ------------------------------------------------------------
    // sequence and verdict
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_stop();
        t_idle();
        t_halt();
        t_stop_reset();
        finish_test();
    end

    // whole run needs about 1300 cycles
    initial
    begin
        #200_000;
        miscompares++;
        finish_test();
    end
endmodule : smc_standby_ctrl_tb
